// >>> hw/wake_pkg.sv
`default_nettype none

package wake_pkg;

  // ==========================================================
  // variants and sizes
  localparam int NUM_TIMERS = 2;
  localparam int CNT_W_LARGE = 35;
  localparam int CNT_W_SMALL = 32;
  localparam logic [34:0] ROLL_LARGE = 35'h0_7FFF_FFFF;
  localparam logic [34:0] ROLL_SMALL = 35'h0_0FFF_FFFF;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // global register offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ACTIVE = 8'h04;
  localparam logic [7:0] OFF_FIRED = 8'h08;
  localparam logic [7:0] OFF_CLKSEL = 8'h0C;
  localparam logic [7:0] OFF_CAL_RES = 8'h10;
  localparam logic [7:0] OFF_CAL_STAT = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_INT_MASK = 8'h1C;

  // ==========================================================
  // per-timer window: addr[7:5] = TMR_WIN0 + timer index
  localparam int TMR_IDX_LSB = 5;
  localparam logic [2:0] TMR_WIN0 = 3'h1;
  localparam logic [4:0] TOFF_IRQ_EN = 5'h00;
  localparam logic [4:0] TOFF_LOAD_LO = 5'h04;
  localparam logic [4:0] TOFF_LOAD_HI = 5'h08;
  localparam logic [4:0] TOFF_CNT_LO = 5'h0C;
  localparam logic [4:0] TOFF_CNT_HI = 5'h10;

  // ==========================================================
  // field positions
  localparam int CMD_START_LSB = 0;
  localparam int CMD_STOP_LSB = 2;
  localparam int CMD_CAL_BIT = 4;
  localparam int CLKSEL_BIT = 0;
  localparam int IRQ_EN_BIT = 0;
  localparam int CAL_BUSY_BIT = 0;
  localparam int INT_CAL_BIT = 2;
  localparam int INT_W = 3;

  // ==========================================================
  // reset values
  localparam logic [2:0] RST_INT_MASK = 3'h7;
  localparam logic RST_CLKSEL = 1'b0;

  // ==========================================================
  // timing
  localparam int SLOW_CLK_NOM_HZ = 32000;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CAL_REF_MHZ = 16;
  localparam int CAL_PERIODS = 20;
  localparam int CAL_NOMINAL = 10000;

endpackage

`default_nettype wire

// >>> hw/wake_counter_core.sv
`timescale 1ns/1ps
`default_nettype none

module wake_counter_core #(
  parameter int CNT_W = 35,
  parameter logic [CNT_W-1:0] ROLL = '1
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // slow tick and commands
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [CNT_W-1:0] load_in,
  // counter state
  output logic [CNT_W-1:0] count_out,
  output logic active_out,
  output logic fire_out
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic active_q;
  logic active_d;
  logic fire_q;
  logic fire_d;

  // ==========================================================
  // countdown
  always_comb
  begin
    count_d = count_q;
    active_d = active_q;
    fire_d = 1'b0;
    if (stop_in)
    begin
      // count is kept so software can read where it stopped
      active_d = 1'b0;
    end
    else if (start_in)
    begin
      count_d = load_in;
      active_d = 1'b1;
    end
    else if (active_q && tick_in)
    begin
      if (count_q == '0)
      begin
        count_d = ROLL;
      end
      else
      begin
        count_d = count_q - CNT_W'(1);
        // a load of one would fire on the very first tick
        fire_d = (count_q == CNT_W'(1));
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_q <= '0;
      active_q <= 1'b0;
      fire_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      active_q <= active_d;
      fire_q <= fire_d;
    end
  end

  assign count_out = count_q;
  assign active_out = active_q;
  assign fire_out = fire_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_LOAD: assert property (
    start_in && !stop_in |=> active_out && count_out == $past(load_in))
    else $error("counter did not load its start count");

  AST_DECREMENT: assert property (
    active_out && tick_in && !start_in && !stop_in
    && count_out > CNT_W'(1)
    |=> count_out == $past(count_out) - CNT_W'(1) && !fire_out)
    else $error("counter did not step down by one on a tick");

  AST_FIRE_AT_ZERO: assert property (
    active_out && tick_in && !start_in && !stop_in
    && count_out == CNT_W'(1) |=> fire_out && count_out == '0)
    else $error("counter reached zero without firing");

  AST_WRAP: assert property (
    active_out && tick_in && !start_in && !stop_in && count_out == '0
    |=> count_out == ROLL && active_out && !fire_out)
    else $error("counter did not wrap and keep running");

  AST_STOP_QUIET: assert property (
    stop_in |=> !active_out && !fire_out && $stable(count_out))
    else $error("stop fired, moved the count or kept running");

endmodule // wake_counter_core

`default_nettype wire

// >>> hw/sleep_wake_down_counter.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - two independent wake down-counters, 35 bits large or 32 small
// - each counter steps down once per slow clock period
// - large variant selects slow clock source; selection survives sleep
// - calibration measures slow clock against 16 MHz reference
// - each counter may raise an interrupt on firing, enabled per timer
// - writing a running counter's interrupt enable stops it, except counter 0 while calibration holds it
// - start loads the given count, then counts down toward zero
// - at zero: fire event, wrap to rollover value, keep counting
// - stopping a counter leaves its interrupt enable unchanged
// - software can stop a counter and read its current count
// - counters run both in sleep and while the processor runs
// - fired bitmap readable; reading it clears reported bits
// - active bitmap readable; stays active after passing zero
// - a commanded stop raises no interrupt
// - calibration uses counter 0 for twenty periods; nominal gives 10000
module sleep_wake_down_counter #(
  parameter int CNT_W = wake_pkg::CNT_W_LARGE
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // slow clock sources
  input wire logic slow_clk_int_in,
  input wire logic slow_clk_ext_in,
  // register port
  input wire logic [wake_pkg::ADDR_W-1:0] addr_in,
  input wire logic [wake_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [wake_pkg::DATA_W-1:0] rdata_out,
  // interrupt
  output logic irq_out
);

  localparam int NT = wake_pkg::NUM_TIMERS;
  localparam int DW = wake_pkg::DATA_W;
  localparam int AW = wake_pkg::ADDR_W;
  localparam int IW = wake_pkg::INT_W;
  localparam int TL = wake_pkg::TMR_IDX_LSB;
  // only the large variant has a selectable slow source
  localparam bit HAS_SRC_SEL = CNT_W > wake_pkg::CNT_W_SMALL;
  localparam logic [CNT_W-1:0] ROLL = HAS_SRC_SEL ?
    CNT_W'(wake_pkg::ROLL_LARGE) : CNT_W'(wake_pkg::ROLL_SMALL);

  typedef enum logic [1:0] {CAL_IDLE, CAL_ARM, CAL_RUN} cal_state_t;

  logic src_sel_q, src_sel_d;
  logic slow_raw;
  logic [2:0] sync_q;
  logic slow_lvl_q, slow_lvl_d;
  logic tick;
  logic [NT-1:0] irq_en_q, irq_en_d;
  logic [DW-1:0] load_lo_q [NT];
  logic [DW-1:0] load_lo_d [NT];
  logic [DW-1:0] load_hi_q [NT];
  logic [DW-1:0] load_hi_d [NT];
  logic [NT-1:0] fired_q, fired_d;
  logic [IW-1:0] int_stat_q, int_stat_d;
  logic [IW-1:0] int_mask_q, int_mask_d;
  logic [IW-1:0] int_clr;
  logic [DW-1:0] rdata_q, rdata_d;
  logic [NT-1:0] sw_start, sw_stop, en_stop;
  logic [NT-1:0] core_start, core_stop;
  logic [NT-1:0] fire, active, fire_evt, t_hit;
  logic [CNT_W-1:0] count [NT];
  logic [CNT_W-1:0] core_load [NT];
  logic [2*DW-1:0] count_ext [NT];
  logic [TL-1:0] t_off;
  logic rd_fired;
  logic cal_go;
  cal_state_t cal_state_q, cal_state_d;
  logic [6:0] cal_acc_q, cal_acc_d, cal_sum;
  logic [DW-1:0] cal_cnt_q, cal_cnt_d;
  logic [DW-1:0] cal_res_q, cal_res_d;
  logic cal_busy, cal_load, cal_finish;

  // ==========================================================
  // slow clock pickup
  // the mux sits ahead of the synchroniser; a source switch may cost or
  // add one tick, which software tolerates since it recalibrates anyway
  assign slow_raw = (HAS_SRC_SEL && src_sel_q) ? slow_clk_ext_in
                                               : slow_clk_int_in;

  always_comb
  begin
    slow_lvl_d = slow_lvl_q;
    if (sync_q[1] == sync_q[2])
      slow_lvl_d = sync_q[2];
  end

  // one tick per slow period, counters never gated by any sleep state
  assign tick = slow_lvl_d && !slow_lvl_q;

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync_q <= 3'h0;
      slow_lvl_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], slow_raw};
      slow_lvl_q <= slow_lvl_d;
    end
  end

  // ==========================================================
  // register decode
  always_comb
  begin
    for (int i = 0; i < NT; i++)
      t_hit[i] = addr_in[AW-1:TL] == 3'(int'(wake_pkg::TMR_WIN0) + i);
  end
  assign t_off = addr_in[TL-1:0];

  always_comb
  begin
    irq_en_d = irq_en_q;
    load_lo_d = load_lo_q;
    load_hi_d = load_hi_q;
    src_sel_d = src_sel_q;
    int_mask_d = int_mask_q;
    sw_start = '0;
    sw_stop = '0;
    en_stop = '0;
    cal_go = 1'b0;
    int_clr = '0;
    rdata_d = '0;
    if (wr_in)
    begin
      if (addr_in == wake_pkg::OFF_CMD)
      begin
        sw_start = wdata_in[wake_pkg::CMD_START_LSB +: NT];
        sw_stop = wdata_in[wake_pkg::CMD_STOP_LSB +: NT];
        cal_go = wdata_in[wake_pkg::CMD_CAL_BIT];
      end
      if (addr_in == wake_pkg::OFF_CLKSEL)
        src_sel_d = wdata_in[wake_pkg::CLKSEL_BIT];
      if (addr_in == wake_pkg::OFF_INT_STAT)
        int_clr = wdata_in[IW-1:0];
      if (addr_in == wake_pkg::OFF_INT_MASK)
        int_mask_d = wdata_in[IW-1:0];
      for (int i = 0; i < NT; i++)
      begin
        if (t_hit[i] && t_off == wake_pkg::TOFF_IRQ_EN)
        begin
          irq_en_d[i] = wdata_in[wake_pkg::IRQ_EN_BIT];
          en_stop[i] = active[i];
        end
        if (t_hit[i] && t_off == wake_pkg::TOFF_LOAD_LO)
          load_lo_d[i] = wdata_in;
        if (t_hit[i] && t_off == wake_pkg::TOFF_LOAD_HI)
          load_hi_d[i] = wdata_in;
      end
    end
    if (rd_in)
    begin
      unique case (addr_in)
        wake_pkg::OFF_ACTIVE: rdata_d = DW'(active);
        wake_pkg::OFF_FIRED: rdata_d = DW'(fired_q);
        wake_pkg::OFF_CLKSEL: rdata_d = DW'(src_sel_q);
        wake_pkg::OFF_CAL_RES: rdata_d = cal_res_q;
        wake_pkg::OFF_CAL_STAT: rdata_d = DW'(cal_busy);
        wake_pkg::OFF_INT_STAT: rdata_d = DW'(int_stat_q);
        wake_pkg::OFF_INT_MASK: rdata_d = DW'(int_mask_q);
        default: rdata_d = '0;
      endcase
      for (int i = 0; i < NT; i++)
      begin
        if (t_hit[i] && t_off == wake_pkg::TOFF_IRQ_EN)
          rdata_d = DW'(irq_en_q[i]);
        if (t_hit[i] && t_off == wake_pkg::TOFF_LOAD_LO)
          rdata_d = load_lo_q[i];
        if (t_hit[i] && t_off == wake_pkg::TOFF_LOAD_HI)
          rdata_d = load_hi_q[i];
        if (t_hit[i] && t_off == wake_pkg::TOFF_CNT_LO)
          rdata_d = count_ext[i][DW-1:0];
        if (t_hit[i] && t_off == wake_pkg::TOFF_CNT_HI)
          rdata_d = count_ext[i][2*DW-1:DW];
      end
    end
    // only bits that were reported are cleared; a new fire always wins
    rd_fired = rd_in && addr_in == wake_pkg::OFF_FIRED;
    fired_d = (fired_q & ~(rd_fired ? fired_q : '0)) | fire_evt;
    int_stat_d = (int_stat_q & ~int_clr) | {cal_finish, fire_evt};
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_en_q <= '0;
      fired_q <= '0;
      src_sel_q <= wake_pkg::RST_CLKSEL;
      int_stat_q <= '0;
      int_mask_q <= wake_pkg::RST_INT_MASK;
      rdata_q <= '0;
      for (int i = 0; i < NT; i++)
      begin
        load_lo_q[i] <= '0;
        load_hi_q[i] <= '0;
      end
    end
    else
    begin
      irq_en_q <= irq_en_d;
      fired_q <= fired_d;
      src_sel_q <= src_sel_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      rdata_q <= rdata_d;
      load_lo_q <= load_lo_d;
      load_hi_q <= load_hi_d;
    end
  end

  assign rdata_out = rdata_q;
  // stopping never touches irq_en, and stop itself never sets status
  assign irq_out = |(int_stat_q & int_mask_q & {1'b1, irq_en_q});

  // ==========================================================
  // calibration: counter 0 times twenty slow periods while a
  // fractional accumulator turns mclk into 16 MHz reference ticks
  assign cal_busy = cal_state_q != CAL_IDLE;
  assign cal_sum = cal_acc_q + 7'(wake_pkg::CAL_REF_MHZ);

  always_comb
  begin
    cal_state_d = cal_state_q;
    cal_acc_d = cal_acc_q;
    cal_cnt_d = cal_cnt_q;
    cal_res_d = cal_res_q;
    cal_load = 1'b0;
    cal_finish = 1'b0;
    unique case (cal_state_q)
      CAL_IDLE:
        if (cal_go)
          cal_state_d = CAL_ARM;
      CAL_ARM:
        // wait for a tick edge so the window spans whole periods
        if (tick)
        begin
          cal_load = 1'b1;
          cal_acc_d = '0;
          cal_cnt_d = '0;
          cal_state_d = CAL_RUN;
        end
      CAL_RUN:
        if (fire[0])
        begin
          cal_finish = 1'b1;
          cal_res_d = cal_cnt_q;
          cal_state_d = CAL_IDLE;
        end
        else if (cal_sum >= 7'(wake_pkg::CLK_FREQ_MHZ))
        begin
          cal_acc_d = cal_sum - 7'(wake_pkg::CLK_FREQ_MHZ);
          cal_cnt_d = cal_cnt_q + DW'(1);
        end
        else
          cal_acc_d = cal_sum;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cal_state_q <= CAL_IDLE;
      cal_acc_q <= 7'h00;
      cal_cnt_q <= '0;
      cal_res_q <= '0;
    end
    else
    begin
      cal_state_q <= cal_state_d;
      cal_acc_q <= cal_acc_d;
      cal_cnt_q <= cal_cnt_d;
      cal_res_q <= cal_res_d;
    end
  end

  // ==========================================================
  // counters; calibration borrows counter 0 and hides its fires
  always_comb
  begin
    core_start = sw_start;
    core_stop = sw_stop | en_stop;
    fire_evt = fire;
    for (int i = 0; i < NT; i++)
      core_load[i] = CNT_W'({load_hi_q[i], load_lo_q[i]});
    if (cal_busy)
    begin
      core_start[0] = cal_load;
      core_stop[0] = cal_finish;
      core_load[0] = CNT_W'(wake_pkg::CAL_PERIODS);
      fire_evt[0] = 1'b0;
    end
    else if (cal_go)
      core_stop[0] = 1'b1;
  end

  for (genvar g = 0; g < NT; g++)
  begin : gen_tmr
    wake_counter_core #(
      .CNT_W(CNT_W),
      .ROLL(ROLL)
    ) u_core (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .tick_in(tick),
      .start_in(core_start[g]),
      .stop_in(core_stop[g]),
      .load_in(core_load[g]),
      .count_out(count[g]),
      .active_out(active[g]),
      .fire_out(fire[g])
    );
    assign count_ext[g] = (2*DW)'(count[g]);

    AST_FIRED_SET: assert property (
      @(posedge mclk_in) disable iff (!rst_b_in)
      fire_evt[g] |=> fired_q[g] && int_stat_q[g])
      else $error("fire did not set fired and interrupt status");

    AST_IRQEN_STOP: assert property (
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_in && t_hit[g] && t_off == wake_pkg::TOFF_IRQ_EN && active[g]
      && !(g == 0 && cal_busy)
      |=> !active[g] && irq_en_q[g] == $past(wdata_in[0]))
      else $error("enable write did not stop the running counter");

    AST_IRQ_RAISE: assert property (
      @(posedge mclk_in) disable iff (!rst_b_in)
      fire_evt[g] && irq_en_q[g] && int_mask_q[g] && !wr_in |=> irq_out)
      else $error("enabled fire did not raise the interrupt");
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_RD_IDLE: assert property (
    !rd_in |=> rdata_out == '0)
    else $error("read data present without a read");

  AST_FIRED_CLEAR: assert property (
    rd_in && addr_in == wake_pkg::OFF_FIRED && fire_evt == '0
    |=> fired_q == '0 && rdata_out == DW'($past(fired_q)))
    else $error("fired read did not report and clear");

  AST_IRQ_CAUSE: assert property (
    irq_out |-> |(int_stat_q & int_mask_q))
    else $error("interrupt without a pending status bit");

  AST_SRC_HOLD: assert property (
    !(wr_in && addr_in == wake_pkg::OFF_CLKSEL) |=> $stable(src_sel_q))
    else $error("clock source changed without a write");

  AST_CAL_LOAD: assert property (
    cal_state_q == CAL_ARM && tick
    |=> active[0] && count[0] == CNT_W'(wake_pkg::CAL_PERIODS))
    else $error("calibration did not load counter 0 with twenty");

  AST_CAL_FINISH: assert property (
    cal_state_q == CAL_RUN && fire[0]
    |=> cal_state_q == CAL_IDLE && !active[0]
    && cal_res_q == $past(cal_cnt_q) && int_stat_q[wake_pkg::INT_CAL_BIT])
    else $error("calibration did not finish cleanly");

  COV_FIRE0: cover property (fire_evt[0]);
  COV_FIRE1: cover property (fire_evt[1] && !irq_en_q[1]);
  COV_CAL_DONE: cover property (cal_finish);
  COV_IRQ_RISE: cover property ($rose(irq_out));

endmodule // sleep_wake_down_counter

`default_nettype wire

// >>> verif/tb_sleep_wake_down_counter.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sleep_wake_down_counter;
  // slow clock period in mclk cycles; half period 400 ns
  localparam int SLOW_PER = 40;
  localparam int CAL_EXP = SLOW_PER * wake_pkg::CAL_PERIODS
    * wake_pkg::CAL_REF_MHZ / wake_pkg::CLK_FREQ_MHZ;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic slow_clk_int_in = 1'b0;
  logic slow_clk_ext_in = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic irq_out;
  logic [31:0] rdata_s;
  logic irq_s;
  localparam logic [31:0] ROLL_S = wake_pkg::ROLL_SMALL[31:0];
  logic [31:0] rv;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  sleep_wake_down_counter #(.CNT_W(wake_pkg::CNT_W_LARGE)) dut (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .slow_clk_int_in(slow_clk_int_in),
    .slow_clk_ext_in(slow_clk_ext_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .irq_out(irq_out)
  );

  // small variant shares the bus so its rollover and fixed source show
  sleep_wake_down_counter #(.CNT_W(wake_pkg::CNT_W_SMALL)) dut_small (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .slow_clk_int_in(slow_clk_int_in),
    .slow_clk_ext_in(slow_clk_ext_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_s),
    .irq_out(irq_s)
  );

  // ==========================================================
  // clocks and hang guard
  initial
  begin
    forever #10 mclk_in = ~mclk_in;
  end

  initial
  begin
    forever #400 slow_clk_int_in = ~slow_clk_int_in;
  end

  // alternate source stands still until a scenario lets it run
  initial
  begin
    forever #800 if (ext_run) slow_clk_ext_in = ~slow_clk_ext_in;
  end

  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  function automatic logic [7:0] ta(input int n, input logic [4:0] off);
    return {wake_pkg::TMR_WIN0 + 3'(n), off};
  endfunction

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_out !== 1'b1 && n < lim)
    begin
      // look after the edge so the value launched there has settled
      @(posedge mclk_in);
      #1;
      n++;
    end
  endtask

  function automatic logic [31:0] flag(input logic b);
    return {31'h0, b};
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check(flag(irq_out), 32'h0);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h0);
    rdchk(wake_pkg::OFF_FIRED, 32'h0);
    rdchk(wake_pkg::OFF_INT_MASK, {29'h0, wake_pkg::RST_INT_MASK});
    rdchk(wake_pkg::OFF_CLKSEL, 32'h0);
    rdchk(ta(0, wake_pkg::TOFF_IRQ_EN), 32'h0);
    rdchk(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h0);
    rdchk(8'hFC, 32'h0);
  endtask

  task automatic t_fire0();
    int n;
    wr(ta(0, wake_pkg::TOFF_IRQ_EN), 32'h1);
    wr(ta(0, wake_pkg::TOFF_LOAD_LO), 32'h3);
    wr(ta(0, wake_pkg::TOFF_LOAD_HI), 32'h0);
    wr(wake_pkg::OFF_CMD, 32'h1);
    wait_irq(400, n);
    // three ticks: two to three slow periods plus synchroniser delay
    check(flag(n >= 2 * SLOW_PER && n <= 3 * SLOW_PER + 6), 32'h1);
    check(flag(irq_out), 32'h1);
    check(flag(irq_s), 32'h1);
    rdchk(ta(0, wake_pkg::TOFF_CNT_LO), 32'h0);
    rdchk(wake_pkg::OFF_FIRED, 32'h1);
    rdchk(wake_pkg::OFF_FIRED, 32'h0);
    repeat (SLOW_PER + 5) @(posedge mclk_in);
    rd(ta(0, wake_pkg::TOFF_CNT_LO), rv);
    check(rv, wake_pkg::ROLL_LARGE[31:0]);
    check(rdata_s, ROLL_S);
    rdchk(ta(0, wake_pkg::TOFF_CNT_HI), {29'h0, wake_pkg::ROLL_LARGE[34:32]});
    rdchk(wake_pkg::OFF_ACTIVE, 32'h1);
    check(flag(irq_out), 32'h1);
    wr(wake_pkg::OFF_INT_STAT, 32'h1);
    check(flag(irq_out), 32'h0);
    wr(wake_pkg::OFF_CMD, 32'h4);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h0);
    rdchk(ta(0, wake_pkg::TOFF_IRQ_EN), 32'h1);
    check(flag(irq_out), 32'h0);
  endtask

  task automatic t_long1();
    wr(ta(1, wake_pkg::TOFF_LOAD_LO), 32'h10);
    wr(ta(1, wake_pkg::TOFF_LOAD_HI), 32'h5);
    wr(wake_pkg::OFF_CMD, 32'h2);
    rdchk(ta(1, wake_pkg::TOFF_CNT_HI), 32'h5);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h2);
    wr(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h1);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h0);
    rdchk(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h1);
    wr(wake_pkg::OFF_CMD, 32'h2);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h2);
    wr(wake_pkg::OFF_CMD, 32'hA);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h0);
    rdchk(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h1);
    repeat (3 * SLOW_PER) @(posedge mclk_in);
    rdchk(ta(1, wake_pkg::TOFF_CNT_HI), 32'h5);
    check(flag(irq_out), 32'h0);
  endtask

  task automatic t_noirq1();
    wr(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h0);
    wr(ta(1, wake_pkg::TOFF_LOAD_LO), 32'h2);
    wr(ta(1, wake_pkg::TOFF_LOAD_HI), 32'h0);
    wr(wake_pkg::OFF_CMD, 32'h2);
    repeat (3 * SLOW_PER + 30) @(posedge mclk_in);
    check(flag(irq_out), 32'h0);
    rdchk(wake_pkg::OFF_INT_STAT, 32'h2);
    rdchk(wake_pkg::OFF_FIRED, 32'h2);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h2);
    wr(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h1);
    check(flag(irq_out), 32'h1);
    wr(wake_pkg::OFF_INT_MASK, 32'h5);
    check(flag(irq_out), 32'h0);
    wr(wake_pkg::OFF_INT_STAT, 32'h2);
    wr(wake_pkg::OFF_INT_MASK, 32'h7);
    check(flag(irq_out), 32'h0);
    wr(ta(1, wake_pkg::TOFF_IRQ_EN), 32'h0);
  endtask

  task automatic t_cal();
    int n;
    wr(wake_pkg::OFF_CMD, 32'h10);
    rdchk(wake_pkg::OFF_CAL_STAT, 32'h1);
    wait_irq(30 * SLOW_PER, n);
    check(flag(irq_out), 32'h1);
    rd(wake_pkg::OFF_CAL_RES, rv);
    // accumulator rounding and tick alignment allow a small spread
    check(flag(rv >= CAL_EXP - 3 && rv <= CAL_EXP + 3), 32'h1);
    rdchk(wake_pkg::OFF_CAL_STAT, 32'h0);
    rdchk(wake_pkg::OFF_INT_STAT, 32'h4);
    rdchk(wake_pkg::OFF_ACTIVE, 32'h0);
    wr(wake_pkg::OFF_INT_STAT, 32'h4);
    check(flag(irq_out), 32'h0);
  endtask

  task automatic t_clksel();
    wr(wake_pkg::OFF_CLKSEL, 32'h1);
    rdchk(wake_pkg::OFF_CLKSEL, 32'h1);
    wr(ta(0, wake_pkg::TOFF_LOAD_LO), 32'h5);
    wr(wake_pkg::OFF_CMD, 32'h1);
    repeat (5 * SLOW_PER) @(posedge mclk_in);
    rd(ta(0, wake_pkg::TOFF_CNT_LO), rv);
    check(rv, 32'h5);
    // the small variant has no source select, so it kept ticking
    rv = rdata_s;
    check(flag(rv == 32'h0 || rv == ROLL_S), 32'h1);
    ext_run = 1'b1;
    repeat (200) @(posedge mclk_in);
    rd(ta(0, wake_pkg::TOFF_CNT_LO), rv);
    check(flag(rv == 32'h3 || rv == 32'h2), 32'h1);
    wr(wake_pkg::OFF_CMD, 32'h4);
    wr(wake_pkg::OFF_CLKSEL, 32'h0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    t_reset();
    t_fire0();
    t_long1();
    t_noirq1();
    t_cal();
    t_clksel();
    complete_run();
  end
endmodule // tb_sleep_wake_down_counter

`default_nettype wire
